// ### rtl/wlp_pkg.sv
package wlp_pkg;
   // Register byte offsets on the AHB-Lite bus.
   localparam logic [7:0] WLP_WD_CTRL_OFF = 8'h00;
   localparam logic [7:0] WLP_WD_KEY_OFF = 8'h04;
   localparam logic [7:0] WLP_WD_CNT_OFF = 8'h08;
   localparam logic [7:0] WLP_LPM_CTRL0_OFF = 8'h0C;
   localparam logic [7:0] WLP_WAKE_SEL_OFF = 8'h10;
   localparam logic [7:0] WLP_STATUS_OFF = 8'h14;
   localparam logic [7:0] WLP_IDLE_CMD_OFF = 8'h18;
   // Watchdog key values.
   localparam logic [7:0] WLP_KEY_ARM = 8'h55;
   localparam logic [7:0] WLP_KEY_CLEAR = 8'hAA;
   // Watchdog counter width and reset pulse length in oscillator clocks.
   localparam int WLP_WD_WIDTH = 8;
   localparam int WLP_WD_PULSE_CYC = 512;
   localparam logic [9:0] WLP_WD_PULSE_LAST = 10'h1FF;
   // Watchdog control register fields.
   localparam int WLP_WDC_DIS_BIT = 0;
   localparam int WLP_WDC_IRQ_MODE_BIT = 1;
   localparam int WLP_WDC_WAKE_EN_BIT = 2;
   localparam logic [2:0] WLP_WDC_RESET = 3'h0;
   // Low-power control register fields.
   localparam int WLP_LPM_LSB = 0;
   localparam int WLP_QUAL_LSB = 2;
   localparam int WLP_QUAL_WIDTH = 6;
   // Status register fields.
   localparam int WLP_ST_MODE_LSB = 0;
   localparam int WLP_ST_ACTIVE_BIT = 2;
   localparam int WLP_ST_MCLK_BIT = 3;
   localparam int WLP_ST_WATCHDOG_RESET_OUT_BIT = 4;
   // AHB-Lite transfer type code used to detect a valid transfer.
   localparam logic [1:0] WLP_HTRANS_NONSEQ = 2'h2;
   // Low-power mode field codes.
   localparam logic [1:0] WLP_MODE_IDLE = 2'h0;
   localparam logic [1:0] WLP_MODE_STANDBY = 2'h1;
   // Controller states.
   typedef enum logic [1:0] {
      WLP_ST_RUN = 2'b00,
      WLP_ST_IDLE = 2'b01,
      WLP_ST_STANDBY = 2'b10,
      WLP_ST_HALT = 2'b11
   } wlp_state_e;
endpackage : wlp_pkg

// ### rtl/wlp_watchdog.sv
module wlp_watchdog
   import wlp_pkg::*;
#(
   parameter int WIDTH = WLP_WD_WIDTH
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Control.
   input wire logic osc_run_i,
   input wire logic disable_i,
   input wire logic irq_mode_i,
   input wire logic key_wr_i,
   input wire logic [7:0] key_data_i,
   // Status.
   output logic [WIDTH-1:0] count_o,
   output logic watchdog_reset_out_n_o,
   output logic overflow_o
);
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic armed_q, armed_d;
   logic [9:0] pulse_q, pulse_d;
   logic busy_q, busy_d;
   logic ovf;

   // Overflow fires when the counter sits at its top while running.
   assign ovf = osc_run_i && !disable_i && (cnt_q == {WIDTH{1'b1}});

   // Counter, key sequence and reset pulse next values.
   always_comb begin
      cnt_d = cnt_q;
      armed_d = armed_q;
      pulse_d = pulse_q;
      busy_d = busy_q;
      if (osc_run_i && !disable_i) begin
         cnt_d = cnt_q + 1'b1;
      end
      if (key_wr_i) begin
         armed_d = (key_data_i == WLP_KEY_ARM);
         if (key_data_i == WLP_KEY_CLEAR && armed_q) begin
            cnt_d = '0;
         end
      end
      if (busy_q) begin
         pulse_d = pulse_q + 1'b1;
         if (pulse_q == WLP_WD_PULSE_LAST) begin
            busy_d = 1'b0;
         end
      end else if (ovf && !irq_mode_i) begin
         busy_d = 1'b1;
         pulse_d = '0;
      end
   end

   // State registers.
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         armed_q <= 1'b0;
         pulse_q <= '0;
         busy_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         armed_q <= armed_d;
         pulse_q <= pulse_d;
         busy_q <= busy_d;
      end
   end

   assign count_o = cnt_q;
   assign watchdog_reset_out_n_o = !busy_q;
   assign overflow_o = ovf;
endmodule : wlp_watchdog

// ### rtl/wlp_wake_qual.sv
module wlp_wake_qual
   import wlp_pkg::*;
#(
   parameter int PINS = 32
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Pins and selection.
   input wire logic [PINS-1:0] port_a_i,
   input wire logic [PINS-1:0] select_i,
   input wire logic [WLP_QUAL_WIDTH-1:0] qual_i,
   input wire logic enable_i,
   // Qualified wake.
   output logic wake_o
);
   logic [WLP_QUAL_WIDTH:0] cnt_q, cnt_d;
   logic low;

   // Any selected pin low is a wake request; wake sources are active low.
   assign low = enable_i && |(select_i & ~port_a_i);

   // Count oscillator clocks while the request stays low.
   always_comb begin
      cnt_d = '0;
      if (low) begin
         cnt_d = (cnt_q > {1'b0, qual_i}) ? cnt_q : cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign wake_o = low && (cnt_q > {1'b0, qual_i});
endmodule : wlp_wake_qual

// ### rtl/wlp_top.sv
// Behaviour
// - 8-bit up counter pulses at maximum
// - Key 0x55 then 0xAA clears counter
// - Disabled watchdog never overflows
// - Reset output low for 512 clocks
// - Watchdog runs on oscillator clock
// - Watchdog interrupt wakes from STANDBY when enabled
// - Watchdog interrupt ends IDLE directly
// - HALT stops oscillator; watchdog no wake
// - Mode field: 00 IDLE, 01 STANDBY, 1X HALT
// - IDLE keeps clocks; exits on interrupt
// - STANDBY stops CPU clocks; listed exits
// - Selected port-A pins wake STANDBY
// - Wake pins qualified by oscillator clocks
// - HALT wakes on reset, port-A, NMI, debugger
// - Wakes active low, held long enough
// - Output pins hold state in low power
// - System clock output stays on in IDLE
// - Debug port works with CPU clock off
// - STANDBY gates all peripherals but watchdog
// - Missing clock freezes watchdog, sets flag
module wlp_top
   import wlp_pkg::*;
#(
   parameter int PINS = 32
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Wake and event inputs.
   input wire logic external_reset_n_i,
   input wire logic nonmaskable_irq_in_n_i,
   input wire logic debugger_wake_n_i,
   input wire logic enabled_irq_i,
   input wire logic missing_clock_i,
   input wire logic idle_instr_i,
   input wire logic [PINS-1:0] port_a_i,
   // Clock gating and outputs.
   output logic oscillator_run_o,
   output logic cpu_clock_in_en_o,
   output logic system_clock_out_en_o,
   output logic periph_clk_en_o,
   output logic jtag_clk_en_o,
   output logic pin_hold_o,
   output logic watchdog_reset_out_n_o,
   output logic watchdog_wake_irq_o,
   output logic interrupt_expansion_wd_o,
   output logic missing_clock_flag_o,
   output logic lowpower_active_o
);
   wlp_state_e state_q, state_d;
   logic [2:0] wdc_q, wdc_d;
   logic [7:0] lpm_q, lpm_d;
   logic [PINS-1:0] wsel_q, wsel_d;
   logic mclk_q, mclk_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic key_wr;
   logic addr_ok;
   logic [7:0] wd_count;
   logic wd_ovf;
   logic wd_rst_n;
   logic pin_wake;
   logic wd_irq;
   logic exit_any;
   logic osc_run;

   // Decodes a write to the given register in the data phase.
   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_pend_q && (wr_addr_q == off);
   endfunction : wr_hit

   // Oscillator stops in HALT and while the input clock is missing.
   assign osc_run = (state_q != WLP_ST_HALT) && !missing_clock_i;

   // Watchdog counter and reset pulse.
   wlp_watchdog #(
      .WIDTH(WLP_WD_WIDTH)
   ) u_wd (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .osc_run_i(osc_run),
      .disable_i(wdc_q[WLP_WDC_DIS_BIT]),
      .irq_mode_i(wdc_q[WLP_WDC_IRQ_MODE_BIT]),
      .key_wr_i(key_wr),
      .key_data_i(hwdata[7:0]),
      .count_o(wd_count),
      .watchdog_reset_out_n_o(wd_rst_n),
      .overflow_o(wd_ovf)
   );

   // Port-A wake qualifier, active in STANDBY and HALT.
   wlp_wake_qual #(
      .PINS(PINS)
   ) u_qual (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .port_a_i(port_a_i),
      .select_i(wsel_q),
      .qual_i(lpm_q[WLP_QUAL_LSB +: WLP_QUAL_WIDTH]),
      .enable_i((state_q == WLP_ST_STANDBY) || (state_q == WLP_ST_HALT)),
      .wake_o(pin_wake)
   );

   // Watchdog interrupt when the overflow is routed as an interrupt.
   assign wd_irq = wd_ovf && wdc_q[WLP_WDC_IRQ_MODE_BIT];

   // Exit conditions per low-power state.
   always_comb begin
      exit_any = 1'b0;
      unique case (state_q)
         WLP_ST_RUN: exit_any = 1'b0;
         WLP_ST_IDLE: exit_any = enabled_irq_i || !nonmaskable_irq_in_n_i
            || wd_irq;
         WLP_ST_STANDBY: exit_any = !nonmaskable_irq_in_n_i || !debugger_wake_n_i
            || pin_wake || (wd_irq && wdc_q[WLP_WDC_WAKE_EN_BIT]);
         WLP_ST_HALT: exit_any = !nonmaskable_irq_in_n_i || !debugger_wake_n_i
            || pin_wake;
      endcase
   end

   // Low-power state machine.
   always_comb begin
      state_d = state_q;
      if (!external_reset_n_i) begin
         state_d = WLP_ST_RUN;
      end else if (state_q == WLP_ST_RUN) begin
         if (idle_instr_i) begin
            if (lpm_q[WLP_LPM_LSB +: 2] == WLP_MODE_IDLE) begin
               state_d = WLP_ST_IDLE;
            end else if (lpm_q[WLP_LPM_LSB +: 2] == WLP_MODE_STANDBY) begin
               state_d = WLP_ST_STANDBY;
            end else begin
               state_d = WLP_ST_HALT;
            end
         end
      end else if (exit_any) begin
         state_d = WLP_ST_RUN;
      end
   end

   // Bus access accepted in the address phase.
   assign addr_ok = hsel && hready && (htrans == WLP_HTRANS_NONSEQ);
   assign key_wr = wr_hit(WLP_WD_KEY_OFF);

   // Register file and bus pipeline next values.
   always_comb begin
      wdc_d = wdc_q;
      lpm_d = lpm_q;
      wsel_d = wsel_q;
      mclk_d = mclk_q || missing_clock_i;
      rdata_d = rdata_q;
      wr_pend_d = addr_ok && hwrite;
      wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
      if (wr_hit(WLP_WD_CTRL_OFF)) begin
         wdc_d = hwdata[2:0];
      end
      if (wr_hit(WLP_LPM_CTRL0_OFF)) begin
         lpm_d = hwdata[7:0];
      end
      if (wr_hit(WLP_WAKE_SEL_OFF)) begin
         wsel_d = hwdata[PINS-1:0];
      end
      if (wr_hit(WLP_STATUS_OFF) && hwdata[WLP_ST_MCLK_BIT] && !missing_clock_i) begin
         mclk_d = 1'b0;
      end
      if (addr_ok && !hwrite) begin
         rdata_d = '0;
         unique case (haddr[7:0])
            WLP_WD_CTRL_OFF: rdata_d[2:0] = wdc_q;
            WLP_WD_CNT_OFF: rdata_d[7:0] = wd_count;
            WLP_LPM_CTRL0_OFF: rdata_d[7:0] = lpm_q;
            WLP_WAKE_SEL_OFF: rdata_d[PINS-1:0] = wsel_q;
            WLP_STATUS_OFF: begin
               rdata_d[WLP_ST_MODE_LSB +: 2] = state_q;
               rdata_d[WLP_ST_ACTIVE_BIT] = (state_q != WLP_ST_RUN);
               rdata_d[WLP_ST_MCLK_BIT] = mclk_q;
               rdata_d[WLP_ST_WATCHDOG_RESET_OUT_BIT] = !wd_rst_n;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   // State and register flip-flops.
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= WLP_ST_RUN;
         wdc_q <= WLP_WDC_RESET;
         lpm_q <= '0;
         wsel_q <= '0;
         mclk_q <= 1'b0;
         rdata_q <= '0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         state_q <= state_d;
         wdc_q <= wdc_d;
         lpm_q <= lpm_d;
         wsel_q <= wsel_d;
         mclk_q <= mclk_d;
         rdata_q <= rdata_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   // Bus answers: zero wait states, always OKAY.
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Clock gating by low-power state.
   assign oscillator_run_o = osc_run;
   assign cpu_clock_in_en_o = (state_q == WLP_ST_RUN) || (state_q == WLP_ST_IDLE);
   assign system_clock_out_en_o = (state_q == WLP_ST_RUN) || (state_q == WLP_ST_IDLE);
   assign periph_clk_en_o = (state_q == WLP_ST_RUN) || (state_q == WLP_ST_IDLE);
   assign jtag_clk_en_o = 1'b1;
   assign pin_hold_o = (state_q != WLP_ST_RUN);
   assign lowpower_active_o = (state_q != WLP_ST_RUN);
   assign watchdog_reset_out_n_o = wd_rst_n;
   assign watchdog_wake_irq_o = wd_irq;
   assign interrupt_expansion_wd_o = wd_irq && (state_q != WLP_ST_HALT);
   assign missing_clock_flag_o = mclk_q;
endmodule : wlp_top

// ### dv/wlp_top_monitor.sv
module wlp_top_monitor (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Watched ports.
   input wire logic idle_instr_i,
   input wire logic external_reset_n_i,
   input wire logic missing_clock_i,
   input wire logic oscillator_run_o,
   input wire logic cpu_clock_in_en_o,
   input wire logic system_clock_out_en_o,
   input wire logic periph_clk_en_o,
   input wire logic jtag_clk_en_o,
   input wire logic pin_hold_o,
   input wire logic watchdog_reset_out_n_o,
   input wire logic interrupt_expansion_wd_o,
   input wire logic missing_clock_flag_o,
   input wire logic lowpower_active_o
);
   logic [9:0] low_q;
   logic [9:0] low_d;
   // Counts the clocks of the present reset pulse.
   always_comb begin
      low_d = watchdog_reset_out_n_o ? 10'h000 : low_q + 10'h001;
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         low_q <= 10'h000;
      end else begin
         low_q <= low_d;
      end
   end
   // Every check runs on the one clock and is off during reset.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_pulse_len: assert property ($rose(watchdog_reset_out_n_o) |-> low_q == 10'h200)
      else $error("reset pulse length");
   a_jtag_live: assert property (jtag_clk_en_o)
      else $error("debug clock gated");
   a_idle_clocks: assert property (lowpower_active_o && cpu_clock_in_en_o |->
      system_clock_out_en_o && oscillator_run_o) else $error("clock off in idle");
   a_sleep_gate: assert property (!cpu_clock_in_en_o |->
      !system_clock_out_en_o && !periph_clk_en_o) else $error("clock on in sleep");
   a_hold_pins: assert property (pin_hold_o == lowpower_active_o)
      else $error("pin hold wrong");
   a_entry_cause: assert property ($rose(lowpower_active_o) |-> $past(idle_instr_i))
      else $error("sleep without idle");
   a_halt_quiet: assert property (!oscillator_run_o && !missing_clock_flag_o |->
      !interrupt_expansion_wd_o) else $error("watchdog irq in halt");
   a_xrs_exit: assert property (!external_reset_n_i |=> !lowpower_active_o)
      else $error("reset kept sleep");
   a_mclk_flag: assert property (missing_clock_i |=> missing_clock_flag_o)
      else $error("missing clock flag");
endmodule : wlp_top_monitor

bind wlp_top wlp_top_monitor u_mon (.core_clk_i, .sys_rst_i, .idle_instr_i,
   .external_reset_n_i, .missing_clock_i, .oscillator_run_o, .cpu_clock_in_en_o,
   .system_clock_out_en_o, .periph_clk_en_o, .jtag_clk_en_o, .pin_hold_o,
   .watchdog_reset_out_n_o, .interrupt_expansion_wd_o, .missing_clock_flag_o,
   .lowpower_active_o);

// ### dv/wlp_cpu_model.sv
module wlp_cpu_model (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Idle request and expansion line.
   input wire logic run_idle_i,
   input wire logic interrupt_expansion_wd_i,
   // CPU signals to the block.
   output logic idle_instr_o,
   output logic enabled_irq_o
);
   logic idle_d;
   logic irq_d;
   // Idle instruction only on request; the watchdog line arrives as an enabled interrupt.
   always_comb begin
      idle_d = run_idle_i;
      irq_d = interrupt_expansion_wd_i;
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_instr_o <= 1'b0;
         enabled_irq_o <= 1'b0;
      end else begin
         idle_instr_o <= idle_d;
         enabled_irq_o <= irq_d;
      end
   end
endmodule : wlp_cpu_model

// ### dv/wlp_top_bench.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module wlp_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic external_reset_n_i = 1'b1;
   logic nonmaskable_irq_in_n_i = 1'b1;
   logic debugger_wake_n_i = 1'b1;
   logic missing_clock_i = 1'b0;
   logic run_idle = 1'b0;
   logic [31:0] port_a_i = 32'hFFFFFFFF;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, idle_instr_i, enabled_irq_i, oscillator_run_o, cpu_clock_in_en_o;
   logic system_clock_out_en_o, periph_clk_en_o, jtag_clk_en_o, pin_hold_o;
   logic watchdog_reset_out_n_o, watchdog_wake_irq_o, interrupt_expansion_wd_o;
   logic missing_clock_flag_o, lowpower_active_o;
   logic [7:0] offs [6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   // Block under test and the CPU beside it.
   wlp_top dut (.core_clk_i, .sys_rst_i, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .external_reset_n_i,
      .nonmaskable_irq_in_n_i, .debugger_wake_n_i, .enabled_irq_i, .missing_clock_i,
      .idle_instr_i, .port_a_i, .oscillator_run_o, .cpu_clock_in_en_o, .system_clock_out_en_o,
      .periph_clk_en_o, .jtag_clk_en_o, .pin_hold_o, .watchdog_reset_out_n_o,
      .watchdog_wake_irq_o, .interrupt_expansion_wd_o, .missing_clock_flag_o,
      .lowpower_active_o);
   wlp_cpu_model cpu (.core_clk_i, .sys_rst_i, .run_idle_i(run_idle),
      .interrupt_expansion_wd_i(interrupt_expansion_wd_o), .idle_instr_o(idle_instr_i),
      .enabled_irq_o(enabled_irq_i));
   // Clock and hang guard.
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // One single AHB-Lite word transfer; read data is taken at the closing edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      hsel <= 1'b1;
      htrans <= wlp_pkg::WLP_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge core_clk_i);
      while (!hreadyout) @(posedge core_clk_i);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk_i);
      while (!hreadyout) @(posedge core_clk_i);
      rd = hrdata;
   endtask : bus
   // Writes the two key values in order.
   task automatic key();
      bus(1'b1, 8'h04, 32'h55);
      bus(1'b1, 8'h04, 32'hAA);
   endtask : key
   // Waits a bounded time for the sleep flag to reach a level, then compares it.
   task automatic wait_lp(input logic v, input int lim);
      n = 0;
      while (lowpower_active_o !== v && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      `CHK("sleep flag", v, lowpower_active_o)
   endtask : wait_lp
   // Sets the low-power control word and has the CPU execute its idle instruction.
   task automatic sleep(input logic [7:0] c);
      bus(1'b1, 8'h0C, {24'h0, c});
      @(posedge core_clk_i);
      run_idle <= 1'b1;
      @(posedge core_clk_i);
      run_idle <= 1'b0;
      wait_lp(1'b1, 6);
   endtask : sleep
   // Pulls one wake pin low for a number of clocks and checks the sleep flag after.
   task automatic pin(input int p, input int len, input logic v);
      @(posedge core_clk_i);
      port_a_i[p] <= 1'b0;
      repeat (len) @(posedge core_clk_i);
      port_a_i[p] <= 1'b1;
      repeat (3) @(negedge core_clk_i);
      `CHK("sleep after pin", v, lowpower_active_o)
   endtask : pin
   // Prints the verdict and stops.
   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // Main sequence.
   initial begin
      repeat (16) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      foreach (offs[i]) begin
         bus(1'b0, offs[i], 32'h0);
         `CHK("reset value", 32'h0, rd)
      end
      `CHK("bus response", 1'b0, hresp)
      key();
      bus(1'b0, 8'h08, 32'h0);
      `CHK("cleared count", 1'b1, rd < 32'h8)
      repeat (100) @(posedge core_clk_i);
      bus(1'b1, 8'h04, 32'hAA);
      bus(1'b0, 8'h08, 32'h0);
      `CHK("count kept", 1'b1, rd > 32'h60)
      // Overflow pulse is timed while software keeps clearing the counter.
      n = 0;
      while (watchdog_reset_out_n_o && n < 400) begin
         @(negedge core_clk_i);
         n++;
      end
      fork
         begin
            n = 0;
            while (!watchdog_reset_out_n_o && n < 600) begin
               @(negedge core_clk_i);
               n++;
            end
         end
         repeat (5) begin
            repeat (90) @(posedge core_clk_i);
            key();
         end
      join
      `CHK("pulse clocks", 512, n)
      bus(1'b1, 8'h00, 32'h1);
      n = 0;
      repeat (300) begin
         @(negedge core_clk_i);
         n += !watchdog_reset_out_n_o;
      end
      `CHK("pulse while off", 0, n)
      // Watchdog interrupt ends IDLE and wakes STANDBY directly.
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, 8'h00, m ? 32'h6 : 32'h2);
         key();
         sleep(m[7:0]);
         `CHK("cpu clock", m == 0, cpu_clock_in_en_o)
         // The watchdog interrupt line must show before the wake it causes.
         n = 0;
         while (watchdog_wake_irq_o !== 1'b1 && n < 320) begin
            @(negedge core_clk_i);
            n++;
         end
         `CHK("wake irq", 1'b1, watchdog_wake_irq_o)
         wait_lp(1'b0, 320);
         `CHK("no pulse", 1'b1, watchdog_reset_out_n_o)
      end
      // Only a selected pin held past its qualifier wakes STANDBY.
      bus(1'b1, 8'h10, 32'h20);
      sleep(8'h21);
      `CHK("oscillator", 1'b1, oscillator_run_o)
      pin(6, 20, 1'b1);
      pin(5, 6, 1'b1);
      pin(5, 14, 1'b0);
      // Both HALT codes stop the oscillator; reset or the non-maskable input ends them.
      for (int m = 2; m < 4; m++) begin
         sleep(m[7:0]);
         `CHK("oscillator", 1'b0, oscillator_run_o)
         @(posedge core_clk_i);
         external_reset_n_i <= (m == 3);
         nonmaskable_irq_in_n_i <= (m == 2);
         wait_lp(1'b0, 6);
         @(posedge core_clk_i);
         external_reset_n_i <= 1'b1;
         nonmaskable_irq_in_n_i <= 1'b1;
      end
      // A lost input clock sets the sticky flag; writing one clears it.
      @(posedge core_clk_i);
      missing_clock_i <= 1'b1;
      @(posedge core_clk_i);
      missing_clock_i <= 1'b0;
      bus(1'b0, 8'h14, 32'h0);
      `CHK("missing flag", 1'b1, rd[3])
      bus(1'b1, 8'h14, 32'h8);
      bus(1'b0, 8'h14, 32'h0);
      `CHK("flag cleared", 1'b0, rd[3])
      end_of_test();
   end
endmodule : wlp_top_bench
